/* File: verilog/asb_pkg.sv */
// Purpose: shared constants and types of the analog scan and output buffer
// Assumes: one 40 MHz board clock
// Notes:   offsets are byte addresses on the register port
package asb_pkg;
  // register offsets
  localparam logic [7:0] BCR_OFS      = 8'h00;
  localparam logic [7:0] SCAN_OFS     = 8'h10;
  localparam logic [7:0] OUT_PORT_OFS = 8'h18;
  localparam logic [7:0] OBC_OFS      = 8'h1c;
  // board control fields
  localparam int BCR_LOW_TERM  = 0;
  localparam int BCR_HIGH_TERM = 1;
  localparam int BCR_OFFSET_BIN = 2;
  localparam int BCR_IN_TRIG   = 3;
  localparam int BCR_THR_RISE  = 4;
  localparam logic [4:0] BCR_RESET = 5'h04;
  // scan configuration fields
  localparam int SCAN_SIZE_LSB = 0;
  localparam int SCAN_SINGLE   = 2;
  localparam int SCAN_SEL_LSB  = 3;
  localparam int SCAN_SRC_LSB  = 7;
  localparam logic [8:0] SCAN_RESET = 9'h000;
  // output sample port fields
  localparam int OUT_CHAN_LSB   = 16;
  localparam int OUT_GROUP_LAST = 18;
  localparam int OUT_BURST_LAST = 19;
  // output buffer control fields
  localparam int OBC_CLEAR   = 15;
  localparam int OBC_FLAG    = 16;
  localparam int OBC_ALM_LSB = 17;
  localparam logic [14:0] THR_RESET = 15'h7ffe;
  // conversion pace: just above 300,000 per second
  localparam int CLK_NS  = 25;
  localparam int CONV_NS = 3333;
  localparam logic [7:0] CONV_CYC = 8'(CONV_NS / CLK_NS);
  // scan size codes
  localparam logic [1:0] SZ_4   = 2'h0;
  localparam logic [1:0] SZ_8   = 2'h1;
  localparam logic [1:0] SZ_16  = 2'h2;
  localparam logic [1:0] SZ_TWO = 2'h3;
  typedef enum logic [1:0] {
    SRC_RATE_A = 2'b00, SRC_RATE_B = 2'b01,
    SRC_EXT    = 2'b10, SRC_SW     = 2'b11
  } asb_src_type;
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00, SC_START = 2'b01, SC_WAIT = 2'b10
  } asb_scan_type;
endpackage : asb_pkg

/* File: verilog/asb_stream_if.sv */
// Purpose: valid/ready carrier between the block's own modules
// Assumes: one clock domain
// Notes:   src drives data, snk answers ready
`timescale 1ns/1ps
`default_nettype none
interface asb_stream_if #(parameter int W = 17);
  logic         valid; // word offered
  logic         ready; // word can be taken
  logic [W-1:0] data;  // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : asb_stream_if
`default_nettype wire

/* File: verilog/asb_skid2.sv */
// Purpose: two-entry buffer so a stalled receiver loses no word
// Assumes: push and pop may coincide
// Notes:   ready is high while a slot is free
`timescale 1ns/1ps
`default_nettype none
module asb_skid2 #(parameter int W = 17) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // filling and draining sides
  asb_stream_if.snk fill,
  asb_stream_if.src drain
);
  logic [W-1:0] e0_q, e0_d; // head entry
  logic [W-1:0] e1_q, e1_d; // second entry
  logic [1:0]   cnt_q, cnt_d; // entries held
  assign fill.ready  = (cnt_q != 2'h2);
  assign drain.valid = (cnt_q != 2'h0);
  assign drain.data  = e0_q;
  ////////////////////////////////////////////////////////////////////////
  // next state: pop first, then push into the first free slot
  always_comb begin
    e0_d  = e0_q;
    e1_d  = e1_q;
    cnt_d = cnt_q;
    if (drain.valid && drain.ready) begin
      e0_d  = e1_q;
      cnt_d = cnt_d - 2'h1;
    end
    if (fill.valid && fill.ready) begin
      if (cnt_d == 2'h0) e0_d = fill.data;
      else e1_d = fill.data;
      cnt_d = cnt_d + 2'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      e0_q  <= '0;
      e1_q  <= '0;
      cnt_q <= 2'h0;
    end else begin
      e0_q  <= e0_d;
      e1_q  <= e1_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : asb_skid2
`default_nettype wire

/* File: verilog/asb_top.sv */
// Purpose: input scan sequencer and output sample buffer control
// Assumes: inputs synchronous to ref_clk; converters sit outside
// Notes:   register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module asb_top #(
  parameter int OUT_DEPTH = 32768
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  // scan clock sources
  input  wire logic        rate_a_tick,
  input  wire logic        rate_b_tick,
  input  wire logic        ext_sync,
  // input converter
  output var  logic        conv_start,
  output var  logic [3:0]  conv_chan,
  input  wire logic        conv_valid,
  input  wire logic [15:0] conv_data,
  // stored input samples toward the input data buffer
  output var  logic        in_sample_valid,
  output var  logic [16:0] in_sample_data,
  input  wire logic        in_sample_ready,
  // output samples toward the transfer fifo
  output var  logic        out_valid,
  output var  logic [15:0] out_sample,
  output var  logic [1:0]  out_chan,
  output var  logic        out_group_last,
  output var  logic        out_burst_last,
  input  wire logic        out_ready,
  // current loop and threshold
  input  wire logic [3:0]  loop_open_alarm,
  output var  logic        low_group_termination_enable,
  output var  logic        high_group_termination_enable,
  output var  logic        thr_event
);
  import asb_pkg::*;
  localparam int AW = $clog2(OUT_DEPTH);

  // scan length from the configuration, two-channel mode first
  function automatic logic [3:0] scan_last(input logic [1:0] sz,
                                           input logic single);
    if (sz == SZ_TWO) scan_last = 4'h1;
    else if (single) scan_last = 4'h0;
    else if (sz == SZ_4) scan_last = 4'h3;
    else if (sz == SZ_8) scan_last = 4'h7;
    else scan_last = 4'hf;
  endfunction : scan_last

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0]  bcr_q, bcr_d;       // board control register
  logic [8:0]  scan_q, scan_d;     // scan configuration
  logic [14:0] thr_q, thr_d;       // output threshold
  logic        clr_q, clr_d;       // output clear in progress
  logic        flag_q, flag_d;     // threshold flag
  logic        tev_q, tev_d;       // threshold edge event
  logic [3:0]  alm_q;              // open loop alarms
  logic [31:0] rdata_q, rdata_d;   // read answer
  logic        ext_q;              // previous external sync
  logic        scan_done;          // last result of a scan taken
  logic [AW:0] cnt_q, cnt_d;       // words in memory
  logic        head_q, head_d;     // output head register full
  logic        wr_bcr, wr_scan, wr_obc, wr_port;
  asb_src_type src;
  assign src = asb_src_type'(scan_q[SCAN_SRC_LSB +: 2]);
  assign wr_bcr  = reg_wr_en && (reg_addr == BCR_OFS);
  assign wr_scan = reg_wr_en && (reg_addr == SCAN_OFS);
  assign wr_obc  = reg_wr_en && (reg_addr == OBC_OFS);
  assign wr_port = reg_wr_en && (reg_addr == OUT_PORT_OFS);

  // register writes, read mux and threshold flag
  always_comb begin
    bcr_d  = bcr_q;
    scan_d = scan_q;
    thr_d  = thr_q;
    clr_d  = 1'b0;
    if (wr_bcr) bcr_d = reg_wdata[4:0];
    if (scan_done && src == SRC_SW) bcr_d[BCR_IN_TRIG] = 1'b0;
    // a new trigger write wins over the clear
    if (wr_bcr && reg_wdata[BCR_IN_TRIG]) bcr_d[BCR_IN_TRIG] = 1'b1;
    if (wr_scan) scan_d = reg_wdata[8:0];
    if (wr_obc) thr_d = reg_wdata[14:0];
    if (wr_obc && reg_wdata[OBC_CLEAR]) clr_d = 1'b1;
    // flag on buffered count
    // taken from the next count so the flag never lags a push, pop or clear
    flag_d = ({{(31-AW){1'b0}}, cnt_d} + {31'h0, head_d})
             > {17'h0, thr_q};
    tev_d = bcr_q[BCR_THR_RISE] ? (flag_d && !flag_q)
                                : (!flag_d && flag_q);
    rdata_d = 32'h0;
    if (reg_rd_en) begin
      unique case (reg_addr)
        BCR_OFS:  rdata_d = {27'h0, bcr_q};
        SCAN_OFS: rdata_d = {23'h0, scan_q};
        OBC_OFS:  rdata_d = {11'h0, alm_q, flag_q, clr_q, thr_q};
        default:  rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcr_q   <= BCR_RESET;
      scan_q  <= SCAN_RESET;
      thr_q   <= THR_RESET;
      clr_q   <= 1'b0;
      flag_q  <= 1'b0;
      tev_q   <= 1'b0;
      alm_q   <= 4'h0;
      rdata_q <= 32'h0;
      ext_q   <= 1'b1;
    end else begin
      bcr_q   <= bcr_d;
      scan_q  <= scan_d;
      thr_q   <= thr_d;
      clr_q   <= clr_d;
      flag_q  <= flag_d;
      tev_q   <= tev_d;
      alm_q   <= loop_open_alarm;
      rdata_q <= rdata_d;
      ext_q   <= ext_sync;
    end
  end
  assign reg_rdata = rdata_q;
  assign thr_event = tev_q;
  assign low_group_termination_enable  = bcr_q[BCR_LOW_TERM];
  assign high_group_termination_enable = bcr_q[BCR_HIGH_TERM];

  ////////////////////////////////////////////////////////////////////////
  // input scan sequencer
  asb_scan_type st_q, st_d;       // sequencer state
  logic [3:0]   chan_q, chan_d;   // channel being converted
  logic [3:0]   left_q, left_d;   // conversions still to go
  logic [7:0]   pace_q, pace_d;   // cycles to next conversion
  logic         start_q, start_d; // conversion start pulse
  logic         clk_evt, go;
  logic [15:0]  coded;
  asb_stream_if #(.W(17)) in_fill ();
  asb_stream_if #(.W(17)) in_drain ();

  always_comb begin
    unique case (src)
      SRC_RATE_A: clk_evt = rate_a_tick;
      SRC_RATE_B: clk_evt = rate_b_tick;
      SRC_EXT:    clk_evt = ext_q && !ext_sync;
      SRC_SW:     clk_evt = bcr_q[BCR_IN_TRIG];
    endcase
  end
  assign go = clk_evt && (st_q == SC_IDLE);
  assign coded = conv_data ^ {!bcr_q[BCR_OFFSET_BIN], 15'h0};
  assign in_fill.data  = {(chan_q == 4'h0), coded};
  assign in_fill.valid = conv_valid && (st_q == SC_WAIT);

  // sequencer next state
  always_comb begin
    st_d      = st_q;
    chan_d    = chan_q;
    left_d    = left_q;
    start_d   = 1'b0;
    scan_done = 1'b0;
    unique case (st_q)
      SC_IDLE: begin
        if (go) begin
          st_d = SC_START;
          chan_d = (scan_q[SCAN_SINGLE] &&
                    scan_q[1:0] != SZ_TWO)
                   ? scan_q[SCAN_SEL_LSB +: 4] : 4'h0;
          left_d = scan_last(scan_q[1:0], scan_q[SCAN_SINGLE]);
        end
      end
      SC_START: begin
        // paced start
        // a start waits for room so its result is never dropped
        if (pace_q == 8'h0 && in_fill.ready) begin
          start_d = 1'b1;
          st_d    = SC_WAIT;
        end
      end
      SC_WAIT: begin
        if (conv_valid) begin
          if (left_q == 4'h0) begin
            st_d      = SC_IDLE;
            scan_done = 1'b1;
          end else begin
            chan_d = chan_q + 4'h1;
            left_d = left_q - 4'h1;
            st_d   = SC_START;
          end
        end
      end
      default: st_d = SC_IDLE;
    endcase
    if (start_d) pace_d = CONV_CYC - 8'h1;
    else if (pace_q != 8'h0) pace_d = pace_q - 8'h1;
    else pace_d = 8'h0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= SC_IDLE;
      chan_q  <= 4'h0;
      left_q  <= 4'h0;
      pace_q  <= 8'h0;
      start_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      chan_q  <= chan_d;
      left_q  <= left_d;
      pace_q  <= pace_d;
      start_q <= start_d;
    end
  end
  assign conv_start = start_q;
  assign conv_chan  = chan_q;

  // input samples stall here when the input buffer is busy
  asb_skid2 #(.W(17)) u_in_buf (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .fill    (in_fill),
    .drain   (in_drain)
  );
  assign in_drain.ready  = in_sample_ready;
  assign in_sample_valid = in_drain.valid;
  assign in_sample_data  = in_drain.data;

  ////////////////////////////////////////////////////////////////////////
  // output sample buffer
  logic [19:0]   mem [OUT_DEPTH];  // sample, channel, two markers
  logic [AW-1:0] wp_q, wp_d;       // write pointer
  logic [AW-1:0] rp_q, rp_d;       // read pointer
  logic [19:0]   hd_q, hd_d;       // head word
  logic          push, pop;
  assign push = wr_port && (cnt_q < (AW+1)'(OUT_DEPTH)) && !clr_q;
  assign pop  = (!head_q || out_ready) && (cnt_q != '0) && !clr_q;

  // pointers, count and head
  always_comb begin
    wp_d   = wp_q + AW'(push);
    rp_d   = rp_q + AW'(pop);
    cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    head_d = pop ? 1'b1 : (head_q && !out_ready);
    // output coding applied as the word enters the head register
    hd_d   = pop ? {mem[rp_q][19:16],
                    mem[rp_q][15:0] ^ {!bcr_q[BCR_OFFSET_BIN], 15'h0}}
                 : hd_q;
    if (clr_q) begin
      wp_d   = '0;
      rp_d   = '0;
      cnt_d  = '0;
      head_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) mem[wp_q] <= {reg_wdata[OUT_BURST_LAST],
                            reg_wdata[OUT_GROUP_LAST],
                            reg_wdata[OUT_CHAN_LSB +: 2],
                            reg_wdata[15:0]};
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      head_q <= 1'b0;
      hd_q   <= 20'h0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      head_q <= head_d;
      hd_q   <= hd_d;
    end
  end
  assign out_valid      = head_q;
  // head sample is already coded, so the pin comes straight from a flop
  assign out_sample     = hd_q[15:0];
  assign out_chan       = hd_q[17:16];
  assign out_group_last = hd_q[18];
  assign out_burst_last = hd_q[19];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_term;
    wr_bcr |=> low_group_termination_enable == $past(reg_wdata[0]);
  endproperty
  a_term: assert property (p_term)
    else $error("termination enable does not follow write");
  property p_pace;
    conv_start |=> !conv_start [*8];
  endproperty
  a_pace: assert property (p_pace)
    else $error("conversions started too close together");
  property p_first;
    go && !scan_q[SCAN_SINGLE] |=> conv_chan == 4'h0;
  endproperty
  a_first: assert property (p_first)
    else $error("multi channel scan not at channel zero");
  property p_two;
    go && scan_q[1:0] == SZ_TWO |=> left_q == 4'h1 && chan_q == 4'h0;
  endproperty
  a_two: assert property (p_two)
    else $error("two channel mode not honoured");
  property p_ext;
    src == SRC_EXT && ext_q && !ext_sync && st_q == SC_IDLE
      |=> st_q == SC_START;
  endproperty
  a_ext: assert property (p_ext)
    else $error("falling sync did not start a scan");
  property p_trig;
    scan_done && src == SRC_SW && !wr_bcr |=> !bcr_q[BCR_IN_TRIG];
  endproperty
  a_trig: assert property (p_trig)
    else $error("software trigger did not clear");
  property p_clear;
    clr_q |=> cnt_q == '0 && !head_q && !clr_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not empty the buffer");
  property p_tag;
    in_fill.valid |-> in_fill.data[16] == (chan_q == 4'h0);
  endproperty
  a_tag: assert property (p_tag)
    else $error("channel zero tag wrong");
  property p_cap;
    cnt_q <= (AW+1)'(OUT_DEPTH);
  endproperty
  a_cap: assert property (p_cap)
    else $error("output buffer over capacity");
  property p_busy;
    st_q == SC_WAIT && !conv_valid |=> st_q == SC_WAIT;
  endproperty
  a_busy: assert property (p_busy)
    else $error("scan left before conversion result");
  c_scan: cover property (scan_done && left_q == 4'h0);
  c_flag: cover property (tev_q);
  c_stall: cover property (in_sample_valid && !in_sample_ready);
endmodule : asb_top
`default_nettype wire

/* File: sim/asb_conv_model.sv */
// Purpose: behavioural input converter facing the scan sequencer
// Assumes: one request in flight, answered once after a varying delay
// Notes:   result is a fixed pattern plus the channel number
`timescale 1ns/1ps
`default_nettype none
module asb_conv_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // conversion request and result
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_chan,
  output var  logic        conv_valid,
  output var  logic [15:0] conv_data
);
  logic [7:0]  wait_q; // cycles left until the result
  logic [3:0]  chan_q; // channel being converted
  logic [31:0] lfsr_q; // delay jitter, prompt or slow
  ////////////////////////////////////////////////////////////////////////////
  // one result per request; data toggles between results so a stale
  // word is never mistaken for a fresh one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q     <= 8'h00;
      chan_q     <= 4'h0;
      lfsr_q     <= 32'h9614;
      conv_valid <= 1'b0;
      conv_data  <= 16'h0000;
    end else begin
      lfsr_q     <= {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : '0);
      conv_valid <= 1'b0;
      conv_data  <= ~conv_data;
      if (conv_start) begin
        // delay from 5 up to 132 cycles
        wait_q <= 8'h05 + {1'b0, lfsr_q[6:0]};
        chan_q <= conv_chan;
      end else if (wait_q == 8'h01) begin
        conv_valid <= 1'b1;
        conv_data  <= 16'ha5a0 + {12'h000, chan_q};
        wait_q     <= 8'h00;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule : asb_conv_model
`default_nettype wire

/* File: sim/test_asb_top.sv */
// Purpose: self-checking bench for the scan and output buffer block
// Assumes: converter model answers every request; host is the bench
// Notes:   fixed-seed shift register drives stalls and sample values
`timescale 1ns/1ps
`default_nettype none
module test_asb_top;
  import asb_pkg::*;
  localparam int DEPTH = 16; // short output buffer keeps the run brief
  // design signals
  logic        ref_clk, rst_n, reg_wr_en, reg_rd_en, rate_a_tick;
  logic        rate_b_tick, ext_sync, conv_start, conv_valid, thr_event;
  logic        in_sample_valid, in_sample_ready, out_valid, out_ready;
  logic        out_group_last, out_burst_last;
  logic        low_group_termination_enable, high_group_termination_enable;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  conv_chan, loop_open_alarm;
  logic [15:0] conv_data, out_sample;
  logic [16:0] in_sample_data;
  logic [1:0]  out_chan;
  // bench state
  int          miscompares, n_tests, n_events, gap;
  logic        hold_out, hold_in;
  logic [31:0] lfsr, rl, board_control_register, rd;
  logic [19:0] outq[$];
  logic [16:0] inq[$];
  logic [3:0]  chq[$];
  asb_top #(.OUT_DEPTH(DEPTH)) u_asb_top (.ref_clk, .rst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .rate_a_tick,
    .rate_b_tick, .ext_sync, .conv_start, .conv_chan, .conv_valid,
    .conv_data, .in_sample_valid, .in_sample_data, .in_sample_ready,
    .out_valid, .out_sample, .out_chan, .out_group_last, .out_burst_last,
    .out_ready, .loop_open_alarm, .low_group_termination_enable,
    .high_group_termination_enable, .thr_event);
  asb_conv_model u_asb_conv_model (.ref_clk, .rst_n, .conv_start,
    .conv_chan, .conv_valid, .conv_data);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0);
  endfunction : nxt
  // expected coding of a sample under the current board control
  function automatic logic [15:0] code(input logic [15:0] v);
    return v ^ (board_control_register[BCR_OFFSET_BIN] ? 16'h0000 : 16'h8000);
  endfunction : code
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr
  task automatic set_bcr(input logic [31:0] v);
    board_control_register = v;
    wr(BCR_OFS, v);
    repeat (2) @(posedge ref_clk);
    #1 check({high_group_termination_enable, low_group_termination_enable},
      v[1:0]);
  endtask : set_bcr
  // host always tags its samples; markers follow chan 3 and batch end
  task automatic put(input logic [31:0] w, input logic last);
    w[18] = (w[17:16] == 2'h3);
    w[19] = last;
    wr(OUT_PORT_OFS, w);
    outq.push_back({w[19:16], code(w[15:0])});
  endtask : put
  task automatic pulse(input logic a, input logic b, input logic e);
    @(posedge ref_clk);
    rate_a_tick <= a;
    rate_b_tick <= b;
    ext_sync    <= e;
    @(posedge ref_clk);
    rate_a_tick <= 1'b0;
    rate_b_tick <= 1'b0;
    ext_sync    <= 1'b0;
  endtask : pulse
  task automatic scan(input asb_src_type s, input logic [1:0] sz,
                      input logic one, input logic [3:0] sel);
    int n;
    logic [3:0] c;
    n = (sz == SZ_TWO) ? 2 : one ? 1 : (4 << sz);
    chq.delete();
    inq.delete();
    wr(SCAN_OFS, 32'({s, sel, one, sz}));
    if (s == SRC_SW) begin
      wr(BCR_OFS, board_control_register | 32'h8);
      rdr(BCR_OFS);
      check(rd[BCR_IN_TRIG], 1'b1);
    // second event lands mid-scan and must be dropped
    end else repeat (2) pulse(s == SRC_RATE_A, s == SRC_RATE_B, s == SRC_EXT);
    repeat (200) @(posedge ref_clk);
    hold_in <= 1'b0;
    repeat (n * 150 + 100) @(posedge ref_clk);
    if (s == SRC_SW) begin
      rdr(BCR_OFS);
      check(rd[BCR_IN_TRIG], 1'b0);
    end
    pulse(s != SRC_RATE_A, s != SRC_RATE_B, s != SRC_EXT);
    repeat (20) @(posedge ref_clk);
    check(chq.size(), n);
    check(inq.size(), n);
    for (int k = 0; k < n; k++) begin
      c = (n == 1) ? sel : k[3:0];
      check(chq[k], c);
      check(inq[k], {c == 4'h0, code(16'ha5a0 + {12'h0, c})});
    end
  endtask : scan
  task automatic wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  // monitors and random stalls of both receivers
  always @(posedge ref_clk) begin
    if (rst_n && out_valid && out_ready)
      check({out_burst_last, out_group_last, out_chan, out_sample},
        outq.size() ? outq.pop_front() : 20'hfffff);
    if (rst_n && in_sample_valid && in_sample_ready)
      inq.push_back(in_sample_data);
    if (rst_n && thr_event)
      n_events++;
    if (rst_n && conv_start) begin
      check(gap >= CONV_CYC, 1'b1);
      chq.push_back(conv_chan);
      // counts cycles from this start up to, but not including, the next one
      gap = 1;
    end else gap++;
    rl = nxt(rl);
    out_ready       <= !hold_out && (rl[0] | rl[1]);
    in_sample_ready <= !hold_in && (rl[2] | rl[3]);
  end
  // watchdog sized well beyond the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {ref_clk, rst_n, reg_wr_en, reg_rd_en, rate_a_tick, rate_b_tick} = '0;
    {ext_sync, out_ready, in_sample_ready, hold_in} = '0;
    {reg_addr, reg_wdata, loop_open_alarm} = '0;
    {miscompares, n_tests, n_events} = '0;
    {lfsr, rl, hold_out, board_control_register} = {32'h9614, 32'h9614, 1'b1, 32'h4};
    gap = 1000;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, port and unmapped reads
    rdr(OBC_OFS);
    check(rd, 32'h0000_7ffe);
    rdr(BCR_OFS);
    check(rd, 32'(BCR_RESET));
    rdr(OUT_PORT_OFS);
    check(rd, 32'h0);
    rdr(8'h04);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) set_bcr(32'h4 | i);
    repeat (4) begin
      lfsr = nxt(lfsr);
      loop_open_alarm <= lfsr[3:0];
      repeat (3) @(posedge ref_clk);
      rdr(OBC_OFS);
      check(rd[20:17], lfsr[3:0]);
    end
    set_bcr(32'h14);
    wr(OBC_OFS, 32'h2);
    put(32'h1234, 1'b0);
    put(32'h25678, 1'b1);
    repeat (4) @(posedge ref_clk);
    rdr(OBC_OFS);
    check(rd[16:0], 17'h00002);
    put(32'h39abc, 1'b1);
    repeat (4) @(posedge ref_clk);
    rdr(OBC_OFS);
    check(rd[16], 1'b1);
    wr(OBC_OFS, 32'h8002);
    outq.delete();
    rdr(OBC_OFS);
    check({rd[16:15], out_valid}, 3'h0);
    set_bcr(32'h4);
    for (int i = 0; i < 3; i++) put(32'h10 + i, i == 2);
    hold_out <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check(n_events, 2);
    check(outq.size(), 0);
    wr(OBC_OFS, 32'h7ffe);
    // random tagged words in both codings
    for (int k = 0; k < 2; k++) begin
      set_bcr(k ? 32'h0 : 32'h4);
      for (int i = 0; i < 24; i++) begin
        lfsr = nxt(lfsr);
        put(lfsr, i == 23);
      end
      repeat (40) @(posedge ref_clk);
    end
    check(outq.size(), 0);
    set_bcr(32'h4);
    scan(SRC_SW, SZ_4, 1'b0, 4'h0);
    scan(SRC_RATE_A, SZ_8, 1'b0, 4'h0);
    scan(SRC_RATE_B, SZ_16, 1'b0, 4'h0);
    scan(SRC_EXT, SZ_TWO, 1'b1, 4'h5);
    lfsr = nxt(lfsr);
    scan(SRC_EXT, lfsr[1:0], 1'b1, lfsr[7:4]);
    // stalled receiver during a two's complement scan
    set_bcr(32'h0);
    hold_in <= 1'b1;
    scan(SRC_RATE_A, SZ_4, 1'b0, 4'h0);
    wrap_up();
  end
endmodule : test_asb_top
`default_nettype wire
